/* hw/asc_top.sv */
// Converter sequencer: Wishbone registers, scan control, oversampling, window check
module asc_top #(
  parameter int NUM_CH = asc_pkg::ASC_NUM_EXT + asc_pkg::ASC_NUM_INT,
  parameter int NUM_TRIG = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_TRIG-1:0] trig_i,
  input wire logic [1:0] lcd_bias_i,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic conv_start_o,
  output logic [4:0] conv_channel_o,
  output logic conv_power_o,
  output logic conv_clk_o,
  output logic thermal_sense_input_en_o,
  output logic bandgap_ref_input_en_o,
  output logic lcd_supply_input_en_o,
  output logic dma_req_o,
  output logic awd_irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > 32)
  begin : g_chk_ch
    $error("asc_top: NUM_CH must be 1 to 32");
  end
  if (NUM_TRIG < 1 || NUM_TRIG > 8)
  begin : g_chk_trig
    $error("asc_top: NUM_TRIG must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  asc_pkg::asc_state_t state_r, state_nxt;
  asc_pkg::asc_ctrl_t ctrl_r, ctrl_nxt;
  asc_pkg::asc_thr_t thr_r, thr_nxt;
  asc_pkg::asc_flags_t flags_r, flags_nxt;
  asc_pkg::asc_data_t data_r, data_nxt;
  logic [31:0] chsel_r, chsel_nxt;
  logic [31:0] wdch_r, wdch_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic [3:0] cdiv_r, cdiv_nxt;
  logic cclk_r, cclk_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic done_s1_r, done_s2_r, done_q_r;
  logic [11:0] data_s1_r, data_s2_r;
  logic [NUM_TRIG-1:0] trig_q_r;
  logic acc_clr, acc_add;
  logic [asc_pkg::ASC_ACC_W-1:0] acc;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lowest selected channel at or above lo; bit 5 tells whether one was found
  function automatic logic [5:0] first_from(input logic [31:0] mask, input logic [5:0] lo);
    logic [5:0] res;
    res = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (mask[i] && 6'(i) >= lo)
      begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Converter status comes from the analog side, so both done and data pass two stages
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_q_r <= 1'b0;
      data_s1_r <= '0;
      data_s2_r <= '0;
      trig_q_r <= '0;
    end
    else
    begin
      done_s1_r <= conv_done_i;
      done_s2_r <= done_s1_r;
      done_q_r <= done_s2_r;
      data_s1_r <= conv_data_i;
      data_s2_r <= data_s1_r;
      trig_q_r <= trig_i;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  asc_accum #(
    .SAMPLE_W(asc_pkg::ASC_SAMPLE_W),
    .ACC_W(asc_pkg::ASC_ACC_W)
  ) u_accum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(acc_clr),
    .add_i(acc_add),
    .sample_i(data_s2_r),
    .acc_o(acc)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic acc_req, wr, rd, done_edge, start_req, stop_req, in_win, watched;
    logic [7:0] adr;
    logic [8:0] n_samp;
    logic [3:0] shift;
    logic [asc_pkg::ASC_ACC_W-1:0] shifted;
    logic [5:0] nxt;
    acc_req = wb_cyc_i & wb_stb_i & ~ack_r;
    wr = acc_req & wb_we_i;
    rd = acc_req & ~wb_we_i;
    adr = {wb_adr_i[7:2], 2'b00};
    done_edge = done_s2_r & ~done_q_r;
    start_req = 1'b0;
    stop_req = 1'b0;
    in_win = 1'b1;
    watched = 1'b0;
    n_samp = ctrl_r.ovs_en ? 9'(asc_pkg::ASC_OVS_BASE << ctrl_r.ovs_ratio) : asc_pkg::ASC_OVS_ONE;
    shift = ctrl_r.ovs_en ? ctrl_r.ovs_shift : 4'h0;
    shifted = acc >> shift;
    nxt = '0;
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    thr_nxt = thr_r;
    flags_nxt = flags_r;
    data_nxt = data_r;
    chsel_nxt = chsel_r;
    wdch_nxt = wdch_r;
    ch_nxt = ch_r;
    cnt_nxt = cnt_r;
    acc_clr = 1'b0;
    acc_add = 1'b0;
    ack_nxt = acc_req;
    rdat_nxt = rdat_r;

    // Bus writes and reads; clears come first so that a hardware set below wins
    if (wr)
    begin
      unique case (adr)
        asc_pkg::ASC_OFF_CTRL: ctrl_nxt = asc_pkg::asc_ctrl_t'(merge(ctrl_r, wb_dat_i, wb_sel_i));
        asc_pkg::ASC_OFF_CHSEL: chsel_nxt = merge(chsel_r, wb_dat_i, wb_sel_i);
        asc_pkg::ASC_OFF_WDCH: wdch_nxt = merge(wdch_r, wb_dat_i, wb_sel_i);
        asc_pkg::ASC_OFF_THR: thr_nxt = asc_pkg::asc_thr_t'(merge(thr_r, wb_dat_i, wb_sel_i));
        asc_pkg::ASC_OFF_STAT: flags_nxt = flags_r & ~asc_pkg::asc_flags_t'(wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0);
        asc_pkg::ASC_OFF_CMD:
        begin
          start_req = wb_sel_i[0] & wb_dat_i[asc_pkg::ASC_CMD_START] & ~ctrl_r.trig_en;
          stop_req = wb_sel_i[0] & wb_dat_i[asc_pkg::ASC_CMD_STOP];
        end
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (adr)
        asc_pkg::ASC_OFF_CTRL: rdat_nxt = ctrl_r;
        asc_pkg::ASC_OFF_CHSEL: rdat_nxt = chsel_r;
        asc_pkg::ASC_OFF_WDCH: rdat_nxt = wdch_r;
        asc_pkg::ASC_OFF_THR: rdat_nxt = thr_r;
        asc_pkg::ASC_OFF_STAT: rdat_nxt = {27'h0, state_r != asc_pkg::ASC_IDLE, flags_r};
        asc_pkg::ASC_OFF_DATA:
        begin
          rdat_nxt = data_r;
          flags_nxt.eoc = 1'b0;
        end
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
    if (ctrl_r.trig_en && trig_i[ctrl_r.trig_sel] && !trig_q_r[ctrl_r.trig_sel])
    begin
      start_req = 1'b1;
    end

    // Sequencer
    unique case (state_r)
      asc_pkg::ASC_IDLE:
      begin
        nxt = first_from(chsel_r, 6'h00);
        if (start_req && nxt[5])
        begin
          ch_nxt = nxt[4:0];
          cnt_nxt = '0;
          acc_clr = 1'b1;
          state_nxt = asc_pkg::ASC_CONV;
        end
      end
      asc_pkg::ASC_CONV:
      begin
        state_nxt = asc_pkg::ASC_WAIT;
      end
      asc_pkg::ASC_WAIT:
      begin
        if (done_edge)
        begin
          acc_add = 1'b1;
          cnt_nxt = cnt_r + 9'h001;
          state_nxt = (cnt_r + 9'h001 == n_samp) ? asc_pkg::ASC_FIN : asc_pkg::ASC_CONV;
        end
      end
      asc_pkg::ASC_FIN:
      begin
        // Shift too small for the ratio drops high bits; software picks both
        data_nxt.result = shifted[asc_pkg::ASC_RESULT_W-1:0];
        data_nxt.chan = ch_r;
        data_nxt.lcd_div = asc_pkg::ASC_DIV_NONE;
        if (ch_r == asc_pkg::ASC_CH_LCD)
        begin
          data_nxt.lcd_div = (lcd_bias_i == asc_pkg::ASC_BIAS_THIRD) ? asc_pkg::ASC_DIV_THIRD
                                                                     : asc_pkg::ASC_DIV_QUARTER;
        end
        flags_nxt.ovr = flags_r.ovr | flags_nxt.eoc;
        flags_nxt.eoc = 1'b1;
        watched = ctrl_r.wd_all | wdch_r[ch_r];
        in_win = data_nxt.result >= thr_r.low && data_nxt.result <= thr_r.high;
        if (ctrl_r.wd_en && watched && !in_win)
        begin
          flags_nxt.awd = 1'b1;
        end
        nxt = first_from(chsel_r, 6'(ch_r) + 6'h01);
        acc_clr = 1'b1;
        cnt_nxt = '0;
        if (ctrl_r.scan && nxt[5])
        begin
          ch_nxt = nxt[4:0];
          state_nxt = asc_pkg::ASC_CONV;
        end
        else
        begin
          flags_nxt.eos = 1'b1;
          state_nxt = asc_pkg::ASC_IDLE;
        end
      end
      default: state_nxt = asc_pkg::ASC_IDLE;
    endcase
    if (stop_req)
    begin
      state_nxt = asc_pkg::ASC_IDLE;
    end

    // Converter clock divider runs only while powered
    cdiv_nxt = '0;
    cclk_nxt = 1'b0;
    if (conv_power_o)
    begin
      cdiv_nxt = (cdiv_r == ctrl_r.clkdiv) ? 4'h0 : cdiv_r + 4'h1;
      cclk_nxt = (cdiv_r == ctrl_r.clkdiv) ? ~cclk_r : cclk_r;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= asc_pkg::ASC_IDLE;
      ctrl_r <= asc_pkg::ASC_CTRL_RST;
      thr_r <= asc_pkg::ASC_THR_RST;
      flags_r <= '0;
      data_r <= '0;
      chsel_r <= asc_pkg::ASC_MASK_RST;
      wdch_r <= asc_pkg::ASC_MASK_RST;
      ch_r <= '0;
      cnt_r <= '0;
      cdiv_r <= '0;
      cclk_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      flags_r <= flags_nxt;
      data_r <= data_nxt;
      chsel_r <= chsel_nxt;
      wdch_r <= wdch_nxt;
      ch_r <= ch_nxt;
      cnt_r <= cnt_nxt;
      cdiv_r <= cdiv_nxt;
      cclk_r <= cclk_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign conv_start_o = state_r == asc_pkg::ASC_CONV;
  assign conv_channel_o = ch_r;
  // Power stays on between oversamples and scan steps, off once the sequencer idles with autoshut set
  assign conv_power_o = ~ctrl_r.autoshut | (state_r != asc_pkg::ASC_IDLE);
  assign conv_clk_o = cclk_r;
  assign thermal_sense_input_en_o = conv_power_o & (ch_r == asc_pkg::ASC_CH_THERMAL);
  assign bandgap_ref_input_en_o = conv_power_o & (ch_r == asc_pkg::ASC_CH_BANDGAP);
  assign lcd_supply_input_en_o = conv_power_o & (ch_r == asc_pkg::ASC_CH_LCD);
  assign dma_req_o = ctrl_r.dma_en & flags_r.eoc;
  assign awd_irq_o = flags_r.awd;

endmodule

/* inc/asc_pkg.sv */
// Constants, register layout and types for the converter sequencer
package asc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ASC_OFF_CTRL = 8'h00;
  localparam logic [7:0] ASC_OFF_CHSEL = 8'h04;
  localparam logic [7:0] ASC_OFF_WDCH = 8'h08;
  localparam logic [7:0] ASC_OFF_THR = 8'h0C;
  localparam logic [7:0] ASC_OFF_STAT = 8'h10;
  localparam logic [7:0] ASC_OFF_DATA = 8'h14;
  localparam logic [7:0] ASC_OFF_CMD = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] ASC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ASC_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] ASC_THR_RST = 32'hFFFF_0000;
  localparam int ASC_ST_BUSY = 4;
  localparam int ASC_CMD_START = 0;
  localparam int ASC_CMD_STOP = 1;

  // ----------------------------------------------------------------
  // Channels and oversampling
  // ----------------------------------------------------------------
  localparam int ASC_NUM_EXT = 16;
  localparam int ASC_NUM_INT = 3;
  localparam logic [4:0] ASC_CH_LCD = 5'h10;
  localparam logic [4:0] ASC_CH_BANDGAP = 5'h11;
  localparam logic [4:0] ASC_CH_THERMAL = 5'h12;
  localparam int ASC_SAMPLE_W = 12;
  localparam int ASC_RESULT_W = 16;
  localparam int ASC_ACC_W = 20;
  localparam logic [8:0] ASC_OVS_BASE = 9'h002;
  localparam logic [8:0] ASC_OVS_ONE = 9'h001;

  // ----------------------------------------------------------------
  // LCD bias tap divisor
  // ----------------------------------------------------------------
  localparam logic [1:0] ASC_BIAS_THIRD = 2'h2;
  localparam logic [2:0] ASC_DIV_THIRD = 3'h3;
  localparam logic [2:0] ASC_DIV_QUARTER = 3'h4;
  localparam logic [2:0] ASC_DIV_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] rsvd;
    logic [3:0] clkdiv;
    logic wd_all;
    logic wd_en;
    logic dma_en;
    logic [2:0] trig_sel;
    logic trig_en;
    logic [3:0] ovs_shift;
    logic [2:0] ovs_ratio;
    logic ovs_en;
    logic autoshut;
    logic scan;
  } asc_ctrl_t;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } asc_thr_t;

  typedef struct packed {
    logic awd;
    logic ovr;
    logic eos;
    logic eoc;
  } asc_flags_t;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [2:0] lcd_div;
    logic [4:0] chan;
    logic [15:0] result;
  } asc_data_t;

  typedef enum logic [3:0] {
    ASC_IDLE = 4'b0001,
    ASC_CONV = 4'b0010,
    ASC_WAIT = 4'b0100,
    ASC_FIN = 4'b1000
  } asc_state_t;

endpackage

/* hw/asc_accum.sv */
// Oversampling accumulator for converter samples
module asc_accum #(
  parameter int SAMPLE_W = 12,
  parameter int ACC_W = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic add_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic [ACC_W-1:0] acc_o
);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;

  // Room for 256 full-scale samples is needed
  if (ACC_W < SAMPLE_W + 8)
  begin : g_chk
    $error("asc_accum: ACC_W too narrow");
  end

  always_comb
  begin
    acc_nxt = acc_r;
    if (clr_i)
    begin
      acc_nxt = '0;
    end
    else if (add_i)
    begin
      acc_nxt = acc_r + ACC_W'(sample_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_r <= '0;
    end
    else
    begin
      acc_r <= acc_nxt;
    end
  end

  assign acc_o = acc_r;

endmodule

/* dv/asc_conv_model.sv */
// Behavioural converter front end that answers the sequencer's start pulses
module asc_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] channel_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [11:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ----------------------------------------------------------------
  // Sample generation
  // ----------------------------------------------------------------
  // Data is scrambled at each start, so a stale sample never looks valid
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
      data_o <= 12'h000;
    end
    else if (start_i)
    begin
      cnt <= 1;
      done_o <= 1'b0;
      data_o <= ~data_o;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt + 1;
      if (cnt == 1)
        data_o <= {channel_i, 7'h0A};
      if (cnt == (slow_i ? 12 : 4))
      begin
        done_o <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule

/* dv/asc_top_checker.sv */
// Port-level assertions for the converter sequencer
module asc_top_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic conv_start_o,
  input wire logic [4:0] conv_channel_o,
  input wire logic conv_power_o,
  input wire logic conv_clk_o,
  input wire logic thermal_sense_input_en_o,
  input wire logic bandgap_ref_input_en_o,
  input wire logic lcd_supply_input_en_o,
  input wire logic awd_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stat_wr;
  assign stat_wr = wb_ack_o && wb_we_i && (wb_adr_i[7:2] == 6'h04);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_hold_chan;
    $stable(conv_channel_o) [*2];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_start_one_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_start_powered: assert property (conv_start_o |-> conv_power_o)
    else $error("start while converter unpowered");
  a_chan_held: assert property (conv_start_o |=> s_hold_chan)
    else $error("channel changed during conversion");
  a_chan_range: assert property (conv_start_o |-> conv_channel_o <= asc_pkg::ASC_CH_THERMAL)
    else $error("channel out of range");
  a_thermal_route: assert property (thermal_sense_input_en_o == (conv_power_o && conv_channel_o == 5'h12))
    else $error("thermal enable wrong");
  a_bandgap_route: assert property (bandgap_ref_input_en_o == (conv_power_o && conv_channel_o == 5'h11))
    else $error("bandgap enable wrong");
  a_lcd_route: assert property (lcd_supply_input_en_o == (conv_power_o && conv_channel_o == 5'h10))
    else $error("lcd enable wrong");
  a_irq_sticky: assert property ($fell(awd_irq_o) |-> stat_wr)
    else $error("watchdog irq fell without clear");
  a_clk_idle: assert property (!conv_power_o [*2] |-> !conv_clk_o)
    else $error("converter clock runs while unpowered");
endmodule

bind asc_top asc_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o),
  .conv_channel_o(conv_channel_o), .conv_power_o(conv_power_o), .conv_clk_o(conv_clk_o),
  .thermal_sense_input_en_o(thermal_sense_input_en_o), .bandgap_ref_input_en_o(bandgap_ref_input_en_o),
  .lcd_supply_input_en_o(lcd_supply_input_en_o), .awd_irq_o(awd_irq_o));

/* dv/asc_top_tb.sv */
// Self-checking bench for the converter sequencer
module asc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [3:0] bsel = 4'hF;
  logic cclk;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] trig = 8'h00;
  logic [1:0] bias = 2'h2;
  logic slow = 1'b0;
  logic done;
  logic [11:0] cdata;
  logic start;
  logic [4:0] chan;
  logic power;
  logic dma;
  logic irq;
  logic [31:0] q;
  int miscompares = 0;
  int total_checks = 0;

  always #12.5 clk_i = ~clk_i;

  asc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .trig_i(trig), .lcd_bias_i(bias),
    .conv_done_i(done), .conv_data_i(cdata), .conv_start_o(start), .conv_channel_o(chan), .conv_power_o(power),
    .conv_clk_o(cclk), .thermal_sense_input_en_o(), .bandgap_ref_input_en_o(), .lcd_supply_input_en_o(),
    .dma_req_o(dma), .awd_irq_o(irq));
  asc_conv_model conv (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .channel_i(chan), .slow_i(slow),
    .done_o(done), .data_o(cdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] smp(input logic [4:0] ch);
    return {4'h0, ch, 7'h0A};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Single classic cycle; read data lands in q at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= bsel;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (ack !== 1'b1)
      chk(32'h0, 32'h1, "bus ack");
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do bus(1'b0, 8'h10, 32'h0); while (q[4] !== 1'b0 && ++n < 3000);
    chk({31'h0, q[4]}, 32'h0, "busy stuck");
  endtask

  task automatic run(input logic [31:0] ctrl, input logic [31:0] chsel);
    bus(1'b1, 8'h00, ctrl);
    bus(1'b1, 8'h04, chsel);
    bus(1'b1, 8'h18, 32'h1);
    wait_idle;
  endtask

  task automatic get_dma(input logic [4:0] ch, input logic [2:0] div);
    int n;
    n = 0;
    while (dma !== 1'b1 && n++ < 500) @(posedge clk_i);
    chk({31'h0, dma}, 32'h1, "dma request");
    bus(1'b0, 8'h14, 32'h0);
    chk(q, {8'h00, div, ch, smp(ch)}, "scan data");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, 32'hFFFF_0000, "thr reset");
    bus(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0, "ctrl reset");
    chk({31'h0, power}, 32'h1, "power without autoshut");
    q[0] = cclk;
    @(posedge clk_i);
    chk({31'h0, cclk}, {31'h0, ~q[0]}, "converter clock");
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, 8'h0C, 32'h0200_0100);
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0200_0100, "thr readback");
    // Only the low byte is enabled and it carries the value already stored
    bsel = 4'h1;
    bus(1'b1, 8'h0C, 32'hFFFF_FF00);
    bsel = 4'hF;
    bus(1'b0, 8'h0C, 32'h0);
    chk(q, 32'h0200_0100, "byte enables");
    $display("regs test done");
  endtask

  task automatic t_single;
    run(32'h0000_0002, 32'h0002_0008);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, {16'h0003, smp(5'h03)}, "lowest channel");
    chk({31'h0, power}, 32'h0, "power off idle");
    slow <= 1'b1;
    bus(1'b1, 8'h18, 32'h1);
    wait_idle;
    bus(1'b1, 8'h18, 32'h1);
    wait_idle;
    chk(q & 32'h5, 32'h5, "overrun");
    bus(1'b1, 8'h10, 32'hF);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b1, 8'h18, 32'h2);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0, "stop mid conversion");
    $display("single test done");
  endtask

  task automatic t_scan;
    bus(1'b1, 8'h00, 32'h0000_4003);
    bus(1'b1, 8'h04, 32'h0007_0004);
    bus(1'b1, 8'h18, 32'h1);
    get_dma(5'h02, 3'h0);
    get_dma(5'h10, 3'h3);
    get_dma(5'h11, 3'h0);
    get_dma(5'h12, 3'h0);
    wait_idle;
    chk(q & 32'h2, 32'h2, "end of scan");
    bias <= 2'h0;
    bus(1'b1, 8'h04, 32'h0001_0000);
    bus(1'b1, 8'h18, 32'h1);
    get_dma(5'h10, 3'h4);
    wait_idle;
    $display("scan test done");
  endtask

  task automatic t_ovs;
    logic [31:0] cfg [3];
    logic [15:0] exp [3];
    cfg = '{32'h0000_0044, 32'h0000_013C, 32'h0000_003C};
    exp = '{smp(5'h05), 16'(smp(5'h05) << 4), 16'(smp(5'h05) << 8)};
    slow <= 1'b0;
    foreach (cfg[i])
    begin
      run(cfg[i], 32'h0000_0020);
      bus(1'b0, 8'h14, 32'h0);
      chk(q, {16'h0005, exp[i]}, "oversampled");
    end
    $display("oversampling test done");
  endtask

  task automatic t_awd;
    run(32'h0001_8001, 32'h0000_0084);
    chk({31'h0, irq}, 32'h1, "window irq");
    bus(1'b1, 8'h10, 32'hF);
    bus(1'b0, 8'h10, 32'h0);
    chk({q[3:0], irq}, 5'h00, "window clear");
    bus(1'b1, 8'h08, 32'h0000_0004);
    run(32'h0000_8001, 32'h0000_0084);
    chk({31'h0, irq}, 32'h0, "unwatched channel");
    $display("window test done");
  endtask

  task automatic t_trig;
    bus(1'b1, 8'h00, 32'h0000_1C00);
    bus(1'b1, 8'h04, 32'h0000_0002);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    chk(q & 32'h10, 32'h0, "command ignored");
    trig <= 8'h04;
    @(posedge clk_i);
    trig <= 8'h00;
    bus(1'b0, 8'h10, 32'h0);
    chk(q & 32'h10, 32'h0, "other trigger");
    trig <= 8'h08;
    @(posedge clk_i);
    trig <= 8'h00;
    wait_idle;
    bus(1'b0, 8'h14, 32'h0);
    chk(q, {16'h0001, smp(5'h01)}, "triggered data");
    $display("trigger test done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_single;
    t_scan;
    t_ovs;
    t_awd;
    t_trig;
    complete_run;
  end

  // Oversampling by 256 dominates; this leaves ample margin
  initial
  begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    complete_run;
  end
endmodule
